// ==== logic/measurement_output_registers.sv ====
// read-only measurement result bank: level, thermal and level change samples
// assumes an acquisition engine on mclk_in and a serial-bus slave issuing byte accesses
//
// Function
// - the three level result bytes carry altitude or pressure as altitude_select chooses.
// - altitude_select high stores altitude in meters, low stores pressure in pascals.
// - altitude is a signed 20-bit Q16.4 value.
// - altitude integer sits in high and mid bytes, fraction in low byte bits 7:4, bits 3:0 zero.
// - pressure is an unsigned 20-bit Q18.2 value.
// - pressure integer fills high, mid and low bits 7:6, fraction in low bits 5:4.
// - status and five result bytes sit at consecutive addresses 00h to 05h for one burst.
// - temperature is signed Q8.4, integer in the high byte, fraction in low byte bits 7:4.
// - the change bytes hold the difference from the previous level sample of the same mode, zero after a mode change or the first sample.
// - an altitude change is signed 20-bit, integer in high and mid, fraction in low bits 7:4.
// - a pressure change is unsigned 20-bit, integer down to low bit 6, fraction in bits 5:4.
// - the change bytes keep updating whatever the fifo mode is.
// - with fifo off, reading the level high byte clears the new-level and level overwrite flags.
// - with fifo off, reading the thermal high byte clears new-thermal and thermal overwrite flags.
// - with fifo on, the level high address returns fifo data and the other four read zero.
`timescale 1ns/10ps
`include "result_bank_cfg.svh"
module measurement_output_registers (
    input  wire logic                    mclk_in,           // device clock, 100 MHz
    input  wire logic                    rst_n_in,          // async reset, active low
    input  wire logic                    altitude_select_in,// first_control_register mode bit
    input  wire logic                    fifo_enable_in,    // fifo mode nonzero
    input  wire logic                    level_valid_in,    // one-cycle pulse, new level sample
    input  wire result_bank_pkg::level_t level_sample_in,   // level_sample_bits, 20-bit code
    input  wire logic                    therm_valid_in,    // one-cycle pulse, new thermal sample
    input  wire result_bank_pkg::therm_t therm_sample_in,   // thermal_sample_bits, 12-bit code
    input  wire result_bank_pkg::byte_t  fifo_data_in,      // byte from fifo read port
    input  wire logic                    rd_en_in,          // one-cycle read strobe
    input  wire logic                    wr_en_in,          // one-cycle write strobe
    input  wire result_bank_pkg::byte_t  addr_in,           // register address
    input  wire result_bank_pkg::byte_t  wdata_in,          // write data, unused by this bank
    output logic                         fifo_pop_out,      // fifo byte consumed
    output result_bank_pkg::byte_t       rdata_out,         // registered read data
    output logic                         new_level_flag_out,      // level sample pending
    output logic                         level_overwrite_flag_out,// level sample lost
    output logic                         new_thermal_flag_out,    // thermal sample pending
    output logic                         thermal_overwrite_flag_out // thermal sample lost
);
    import result_bank_pkg::*;

    level_t level_r, level_nxt;
    level_t change_r, change_nxt;
    therm_t therm_r, therm_nxt;
    logic   mode_r, mode_nxt;
    logic   have_prev_r, have_prev_nxt;
    logic   nlev_r, nlev_nxt, olev_r, olev_nxt;
    logic   nthm_r, nthm_nxt, othm_r, othm_nxt;
    byte_t  rdata_r, rdata_nxt;
    byte_t  status_v;
    logic   rd_lev_hi, rd_thm_hi;

    // sample capture and delta; whole words load at once
    always_comb begin
        level_nxt     = level_r;
        change_nxt    = change_r;
        mode_nxt      = mode_r;
        have_prev_nxt = have_prev_r;
        therm_nxt     = therm_r;
        if (level_valid_in) begin
            level_nxt     = level_sample_in;
            mode_nxt      = altitude_select_in;
            have_prev_nxt = 1'b1;
            // same-mode difference; first sample or mode change gives zero
            if (have_prev_r && (mode_r == altitude_select_in)) begin
                change_nxt = level_t'(level_sample_in - level_r);
            end else begin
                change_nxt = '0;
            end
        end
        if (therm_valid_in) begin
            therm_nxt = therm_sample_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_r     <= '0;
            change_r    <= '0;
            therm_r     <= '0;
            mode_r      <= 1'b0;
            have_prev_r <= 1'b0;
        end else begin
            level_r     <= level_nxt;
            change_r    <= change_nxt;
            therm_r     <= therm_nxt;
            mode_r      <= mode_nxt;
            have_prev_r <= have_prev_nxt;
        end
    end

    assign rd_lev_hi = rd_en_in && !fifo_enable_in && (addr_in == `ADDR_LEVEL_HIGH);
    assign rd_thm_hi = rd_en_in && !fifo_enable_in && (addr_in == `ADDR_THERM_HIGH);

    // data-ready flags; a new sample wins over a clearing read
    always_comb begin
        nlev_nxt = nlev_r;
        olev_nxt = olev_r;
        nthm_nxt = nthm_r;
        othm_nxt = othm_r;
        if (rd_lev_hi) begin
            nlev_nxt = 1'b0;
            olev_nxt = 1'b0;
        end
        if (rd_thm_hi) begin
            nthm_nxt = 1'b0;
            othm_nxt = 1'b0;
        end
        if (level_valid_in) begin
            nlev_nxt = 1'b1;
            if (nlev_r && !rd_lev_hi) begin
                olev_nxt = 1'b1;
            end
        end
        if (therm_valid_in) begin
            nthm_nxt = 1'b1;
            if (nthm_r && !rd_thm_hi) begin
                othm_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nlev_r <= 1'b0;
            olev_r <= 1'b0;
            nthm_r <= 1'b0;
            othm_r <= 1'b0;
        end else begin
            nlev_r <= nlev_nxt;
            olev_r <= olev_nxt;
            nthm_r <= nthm_nxt;
            othm_r <= othm_nxt;
        end
    end

    // status byte shown at 00h
    always_comb begin
        status_v = 8'h00;
        status_v[`STAT_OVERRUN_ANY] = olev_r | othm_r;
        status_v[`STAT_LEVEL_OVW]   = olev_r;
        status_v[`STAT_THERM_OVW]   = othm_r;
        status_v[`STAT_READY_ANY]   = nlev_r | nthm_r;
        status_v[`STAT_NEW_LEVEL]   = nlev_r;
        status_v[`STAT_NEW_THERM]   = nthm_r;
    end

    // read mux; writes have no path into this bank
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_en_in) begin
            if (addr_in == `ADDR_STATUS || addr_in == `ADDR_STATUS_ALIAS) begin
                rdata_nxt = status_v;
            end else if (addr_in == `ADDR_LEVEL_HIGH) begin
                rdata_nxt = fifo_enable_in ? fifo_data_in : level_r[19:12];
            end else if (fifo_enable_in && addr_in >= `ADDR_LEVEL_MID
                         && addr_in <= `ADDR_THERM_LOW) begin
                rdata_nxt = 8'h00;
            end else if (addr_in == `ADDR_LEVEL_MID) begin
                rdata_nxt = level_r[11:4];
            end else if (addr_in == `ADDR_LEVEL_LOW) begin
                rdata_nxt = {level_r[3:0], 4'h0};
            end else if (addr_in == `ADDR_THERM_HIGH) begin
                rdata_nxt = therm_r[11:4];
            end else if (addr_in == `ADDR_THERM_LOW) begin
                rdata_nxt = {therm_r[3:0], 4'h0};
            end else if (addr_in == `ADDR_CHANGE_HIGH) begin
                rdata_nxt = change_r[19:12];
            end else if (addr_in == `ADDR_CHANGE_MID) begin
                rdata_nxt = change_r[11:4];
            end else if (addr_in == `ADDR_CHANGE_LOW) begin
                rdata_nxt = {change_r[3:0], 4'h0};
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_r <= `RESULT_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // writes are accepted by the bus and dropped here
    logic unused_wr;
    assign unused_wr = wr_en_in & (^wdata_in);

    assign fifo_pop_out = rd_en_in && fifo_enable_in && (addr_in == `ADDR_LEVEL_HIGH);
    assign rdata_out                  = rdata_r;
    assign new_level_flag_out         = nlev_r;
    assign level_overwrite_flag_out   = olev_r;
    assign new_thermal_flag_out       = nthm_r;
    assign thermal_overwrite_flag_out = othm_r;

endmodule // measurement_output_registers

// ==== logic/result_bank_cfg.svh ====
// offsets, field positions and reset values of the measurement result bank
// included by the package and the bank module; definitions only
`ifndef RESULT_BANK_CFG_SVH
`define RESULT_BANK_CFG_SVH
`define ADDR_STATUS       8'h00
`define ADDR_LEVEL_HIGH   8'h01
`define ADDR_LEVEL_MID    8'h02
`define ADDR_LEVEL_LOW    8'h03
`define ADDR_THERM_HIGH   8'h04
`define ADDR_THERM_LOW    8'h05
`define ADDR_STATUS_ALIAS 8'h06
`define ADDR_CHANGE_HIGH  8'h07
`define ADDR_CHANGE_MID   8'h08
`define ADDR_CHANGE_LOW   8'h09
`define RESULT_RESET      8'h00
`define LEVEL_BITS        20
`define THERM_BITS        12
`define STAT_OVERRUN_ANY  7
`define STAT_LEVEL_OVW    6
`define STAT_THERM_OVW    5
`define STAT_READY_ANY    3
`define STAT_NEW_LEVEL    2
`define STAT_NEW_THERM    1
`endif

// ==== logic/result_bank_pkg.sv ====
// types shared by the result bank and its bench
// assumes the cfg header sits beside it
`include "result_bank_cfg.svh"
package result_bank_pkg;
    typedef logic [7:0]               byte_t;
    typedef logic [`LEVEL_BITS-1:0]   level_t;
    typedef logic [`THERM_BITS-1:0]   therm_t;
endpackage

// ==== tb/result_bank_props.sv ====
// checker on the result bank ports
// bound into every measurement_output_registers instance
`timescale 1ns/10ps
module result_bank_props (
    input wire logic                   mclk_in,        // clock
    input wire logic                   rst_n_in,       // reset
    input wire logic                   fifo_enable_in, // fifo on
    input wire logic                   level_valid_in, // level strobe
    input wire result_bank_pkg::byte_t fifo_data_in,   // fifo byte
    input wire logic                   rd_en_in,       // read
    input wire logic                   wr_en_in,       // write
    input wire result_bank_pkg::byte_t addr_in,        // address
    input wire result_bank_pkg::byte_t rdata_out,      // read data
    input wire logic                   fifo_pop_out,   // pop
    input wire logic                   new_level_flag_out,      // new level
    input wire logic                   level_overwrite_flag_out // level lost
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic rd_p1;
    logic rd_f1;
    assign rd_p1 = rd_en_in && !fifo_enable_in && addr_in == 8'h01;
    assign rd_f1 = rd_en_in && fifo_enable_in && addr_in == 8'h01;
    property p_fifo_rd; rd_f1 |=> rdata_out == $past(fifo_data_in); endproperty
    a_fifo_rd: assert property (p_fifo_rd) else $error("fifo byte lost");
    property p_pop; fifo_pop_out == rd_f1; endproperty
    a_pop: assert property (p_pop) else $error("pop wrong");
    property p_zero;
        rd_en_in && fifo_enable_in && addr_in inside {[8'h02:8'h05]} |=> rdata_out == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("fifo mode byte not zero");
    property p_clr; rd_p1 && !level_valid_in |=> !new_level_flag_out && !level_overwrite_flag_out;
    endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared");
    property p_set; level_valid_in |=> new_level_flag_out; endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_ovw; level_valid_in && new_level_flag_out && !rd_p1 |=> level_overwrite_flag_out;
    endproperty
    a_ovw: assert property (p_ovw) else $error("overwrite missed");
    property p_hold; wr_en_in && !rd_en_in |=> $stable(rdata_out); endproperty
    a_hold: assert property (p_hold) else $error("write changed data");
    property p_stat;
        rd_en_in && addr_in == 8'h00 && !level_valid_in |=> rdata_out[2] == $past(new_level_flag_out);
    endproperty
    a_stat: assert property (p_stat) else $error("status bit wrong");
    c_fifo: cover property (rd_f1);
    c_ovw: cover property (level_overwrite_flag_out);
    c_clr: cover property (rd_p1 ##1 !new_level_flag_out);
endmodule // result_bank_props
bind measurement_output_registers result_bank_props i_props (.mclk_in, .rst_n_in,
    .fifo_enable_in, .level_valid_in, .fifo_data_in, .rd_en_in, .wr_en_in, .addr_in,
    .rdata_out, .fifo_pop_out, .new_level_flag_out, .level_overwrite_flag_out);

// ==== tb/burst_reader.sv ====
// host model: reads a run of bytes at rising addresses
// one read per cycle; byte i lands in data_out[i]
`timescale 1ns/10ps
module burst_reader (
    input  wire logic                   mclk_in,     // clock
    input  wire logic                   rst_n_in,    // reset
    input  wire logic                   start_in,    // begin run
    input  wire result_bank_pkg::byte_t first_in,    // first address
    input  wire logic [2:0]             count_in,    // bytes to read
    input  wire result_bank_pkg::byte_t rdata_in,    // read data
    output logic                        rd_en_out,   // read strobe
    output result_bank_pkg::byte_t      addr_out,    // address
    output logic                        busy_out,    // run active
    output result_bank_pkg::byte_t      data_out [6] // bytes read
);
    logic [2:0] left_r;
    logic [2:0] pos_r;
    logic       got_r;
    assign rd_en_out = left_r != 3'h0;
    assign busy_out = rd_en_out || got_r || start_in;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {left_r, pos_r, got_r, addr_out} <= '0;
        end else begin
            got_r <= rd_en_out;
            if (got_r) data_out[pos_r - 3'h1] <= rdata_in;
            if (start_in) {left_r, pos_r, addr_out} <= {count_in, 3'h0, first_in};
            else if (rd_en_out)
                {left_r, pos_r, addr_out} <= {left_r - 3'h1, pos_r + 3'h1, addr_out + 8'h01};
        end
    end
endmodule // burst_reader

// ==== tb/tb_top.sv ====
// bench for the result bank: table of samples, then hand-written cases
// burst_reader issues every read; inputs move on rising edges
`timescale 1ns/10ps
module tb_top;
    import result_bank_pkg::*;
    typedef struct {logic altitude_select; level_t lvl; therm_t th; logic [39:0] res; logic [23:0] dl;} row_s;
    row_s rows [4] = '{'{1'b0, 20'h18a5e, 12'h19c, 40'h18a5e019c0, 24'h000000},
        '{1'b0, 20'h18a62, 12'he88, 40'h18a620e880, 24'h000040},
        '{1'b1, 20'hfff38, 12'h19c, 40'hfff38019c0, 24'h000000},
        '{1'b1, 20'h00048, 12'h19c, 40'h00048019c0, 24'h001100}};
    logic   mclk_in, rst_n_in, altitude_select, fen, lv, tv, wr, rd, start, busy, nl, lo, nt, tw;
    level_t lvl;
    therm_t th;
    byte_t  fdata, addr, rdata, first, got [6];
    logic [2:0] cnt;
    int     n_errors = 0, n_compared = 0, j;
    measurement_output_registers i_dut (.mclk_in, .rst_n_in, .altitude_select_in(altitude_select),
        .fifo_enable_in(fen), .level_valid_in(lv), .level_sample_in(lvl), .therm_valid_in(tv),
        .therm_sample_in(th), .fifo_data_in(fdata), .rd_en_in(rd), .wr_en_in(wr),
        .addr_in(addr), .wdata_in(8'hff), .fifo_pop_out(), .rdata_out(rdata),
        .new_level_flag_out(nl), .level_overwrite_flag_out(lo), .new_thermal_flag_out(nt),
        .thermal_overwrite_flag_out(tw));
    burst_reader i_host (.mclk_in, .rst_n_in, .start_in(start), .first_in(first),
        .count_in(cnt), .rdata_in(rdata), .rd_en_out(rd), .addr_out(addr), .busy_out(busy),
        .data_out(got));
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic chk(input byte_t g, input byte_t e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic sample(input logic a, input level_t l, input therm_t t);
        @(posedge mclk_in);
        {altitude_select, lvl, th, lv, tv} <= {a, l, t, 2'b11};
        @(posedge mclk_in);
        {lv, tv} <= 2'b00;
    endtask
    task automatic burst(input byte_t a, input logic [2:0] n);
        int k;
        @(posedge mclk_in);
        {start, first, cnt} <= {1'b1, a, n};
        @(posedge mclk_in);
        start <= 1'b0;
        for (k = 0; k < 20; k++) begin
            #1;
            if (!busy) break;
            @(posedge mclk_in);
        end
        if (k == 20) begin
            n_errors++;
            results();
        end
    endtask
    task automatic results;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {rst_n_in, altitude_select, fen, lv, tv, wr, start, lvl, th, fdata, first, cnt} = '0;
        repeat (6) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        foreach (rows[i]) begin
            sample(rows[i].altitude_select, rows[i].lvl, rows[i].th);
            burst(8'h00, 3'd6);
            chk(got[0], 8'h0e);
            for (j = 1; j < 6; j++) chk(got[j], rows[i].res[47-8*j -: 8]);
            burst(8'h07, 3'd3);
            for (j = 0; j < 3; j++) chk(got[j], rows[i].dl[23-8*j -: 8]);
        end
        burst(8'h01, 3'd0);
        @(posedge mclk_in);
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
        burst(8'h01, 3'd1);
        chk(got[0], 8'h00);
        sample(1'b1, 20'h00058, 12'h19c);
        sample(1'b1, 20'h00058, 12'h19c);
        burst(8'h00, 3'd1);
        chk(got[0], 8'hee);
        burst(8'h01, 3'd1);
        chk({4'h0, nl, lo, nt, tw}, 8'h03);
        burst(8'h04, 3'd1);
        chk({4'h0, nl, lo, nt, tw}, 8'h00);
        @(posedge mclk_in);
        {fen, fdata} <= {1'b1, 8'h5a};
        sample(1'b1, 20'h00068, 12'h19c);
        burst(8'h01, 3'd5);
        chk(got[0], 8'h5a);
        for (j = 1; j < 5; j++) chk(got[j], 8'h00);
        burst(8'h07, 3'd3);
        chk(got[1], 8'h01);
        @(posedge mclk_in);
        {rst_n_in, fen} <= 2'b00;
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        burst(8'h00, 3'd6);
        for (j = 0; j < 6; j++) chk(got[j], 8'h00);
        results();
    end
endmodule // tb_top
